// ==== inc/acac_pkg.sv ====
// constants, register map and carrier types of the converter control block
package acac_pkg;

  // register byte offsets on the apb word grid
  localparam logic [7:0] ACAC_OFF_CTL0   = 8'h00;
  localparam logic [7:0] ACAC_OFF_CTL1   = 8'h04;
  localparam logic [7:0] ACAC_OFF_RES_HI = 8'h08;
  localparam logic [7:0] ACAC_OFF_RES_LO = 8'h0C;
  localparam logic [7:0] ACAC_OFF_THR_HI = 8'h10;
  localparam logic [7:0] ACAC_OFF_THR_LO = 8'h14;

  // control register 1 field positions
  localparam int ACAC_C1_MODE_LSB = 0;
  localparam int ACAC_C1_LO_EN    = 3;
  localparam int ACAC_C1_HI_EN    = 4;
  localparam int ACAC_C1_REFH     = 5;
  localparam int ACAC_C1_LO_STAT  = 6;
  localparam int ACAC_C1_HI_STAT  = 7;
  localparam int ACAC_C1_BUSY     = 8;
  localparam int ACAC_C1_POWERED  = 9;

  // reset values
  localparam logic [7:0] ACAC_CTL0_RST = 8'h00;
  localparam logic [7:0] ACAC_THR_RST  = 8'h00;

  // reference code that means internal reference is off
  localparam logic [1:0] ACAC_REF_OFF = 2'h0;

  // timing in system clock cycles
  localparam int ACAC_IDLE_CYCLES  = 160;
  localparam int ACAC_PWRUP_CYCLES = 40;
  localparam int ACAC_CONV_CYCLES  = 5129;
  localparam int ACAC_REP_CYCLES   = 256;
  localparam int ACAC_CNT_W        = 13;

  localparam int ACAC_RAW_W = 13;

  typedef enum logic [1:0] {
    ACAC_S_IDLE   = 2'b00,
    ACAC_S_PWRUP  = 2'b01,
    ACAC_S_CONV   = 2'b11,
    ACAC_S_REPEAT = 2'b10
  } acac_state_t;

  typedef struct packed {
    logic       conversion_go;
    logic       vref_level_lower_bit;
    logic       vref_pin_out;
    logic       repeat_select;
    logic [3:0] input_channel_sel;
  } acac_ctl0_t;

  typedef struct packed {
    logic       vref_level_upper_bit;
    logic       upper_alarm_en;
    logic       lower_alarm_en;
    logic [2:0] input_stage_mode;
  } acac_ctl1_t;

endpackage

// ==== rtl/acac_top.sv ====
// sequencing, result placement, alarms and apb registers of the converter
`timescale 1ns/100ps
`default_nettype none
module acac_top
  import acac_pkg::*;
#(
  parameter int CONV_CYCLES = ACAC_CONV_CYCLES
) (
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [7:0]            PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic [ACAC_RAW_W-1:0] SAMPLE_DATA,
  output logic                       ANALOG_POWERED,
  output logic                       CONV_ACTIVE,
  output logic      [3:0]            INPUT_CHANNEL_SEL,
  output logic      [2:0]            INPUT_STAGE_MODE,
  output logic      [1:0]            VREF_LEVEL,
  output logic                       VREF_PIN_OUT,
  output logic                       ADC_IRQ
);

  localparam logic [ACAC_CNT_W-1:0] IDLE_LAST  = ACAC_CNT_W'(ACAC_IDLE_CYCLES - 1);
  localparam logic [ACAC_CNT_W-1:0] PWRUP_LAST = ACAC_CNT_W'(ACAC_PWRUP_CYCLES - 1);
  localparam logic [ACAC_CNT_W-1:0] CONV_LAST  = ACAC_CNT_W'(CONV_CYCLES - 1);
  localparam logic [ACAC_CNT_W-1:0] REP_LAST   = ACAC_CNT_W'(ACAC_REP_CYCLES - 1);

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  acac_ctl0_t            ctl0_q;
  acac_ctl1_t            ctl1_q;
  logic [7:0]            thr_hi_q;
  logic [7:0]            thr_lo_q;
  logic [7:0]            res_hi_q;
  logic [7:0]            res_lo_q;
  logic                  hi_stat_q;
  logic                  lo_stat_q;
  acac_state_t           state_q;
  logic [ACAC_CNT_W-1:0] cnt_q;
  logic [ACAC_CNT_W-1:0] idle_q;
  logic                  powered_q;
  logic                  irq_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;

  logic       wr_en;
  logic       wr_ctl0;
  logic       wr_ctl1;
  logic       wr_thr_hi;
  logic       wr_thr_lo;
  logic       setup;
  logic       mapped;
  logic       done;
  logic       first_done;
  logic       hi_hit;
  logic       lo_hit;
  logic [7:0] cmp_bits;
  logic       is_neg;
  logic       start_ok;

  //////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait-free access phase after every setup
  assign setup  = PSEL && !PENABLE;
  assign wr_en  = PSEL && PENABLE && pready_q && PWRITE;

  // address decode; result registers are read-only, so writes to them are dropped
  always_comb begin
    mapped = 1'b0;
    if (hit(PADDR, ACAC_OFF_CTL0)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, ACAC_OFF_CTL1)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, ACAC_OFF_RES_HI)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, ACAC_OFF_RES_LO)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, ACAC_OFF_THR_HI)) begin
      mapped = 1'b1;
    end else if (hit(PADDR, ACAC_OFF_THR_LO)) begin
      mapped = 1'b1;
    end
  end

  // one write strobe per writable register, decoded once
  always_comb begin
    wr_ctl0   = 1'b0;
    wr_ctl1   = 1'b0;
    wr_thr_hi = 1'b0;
    wr_thr_lo = 1'b0;
    if (wr_en) begin
      if (hit(PADDR, ACAC_OFF_CTL0)) begin
        wr_ctl0 = 1'b1;
      end else if (hit(PADDR, ACAC_OFF_CTL1)) begin
        wr_ctl1 = 1'b1;
      end else if (hit(PADDR, ACAC_OFF_THR_HI)) begin
        wr_thr_hi = 1'b1;
      end else if (hit(PADDR, ACAC_OFF_THR_LO)) begin
        wr_thr_lo = 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !mapped;
    end
  end

  // read data is captured in the setup cycle so it leaves a flop
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      prdata_q <= 32'h0000_0000;
      if (PWRITE) begin
        // writes answer with zero, never with a stale read word
      end else if (hit(PADDR, ACAC_OFF_CTL0)) begin
        prdata_q[7:0] <= ctl0_q;
      end else if (hit(PADDR, ACAC_OFF_CTL1)) begin
        prdata_q[ACAC_C1_MODE_LSB +: 3] <= ctl1_q.input_stage_mode;
        prdata_q[ACAC_C1_LO_EN]         <= ctl1_q.lower_alarm_en;
        prdata_q[ACAC_C1_HI_EN]         <= ctl1_q.upper_alarm_en;
        prdata_q[ACAC_C1_REFH]          <= ctl1_q.vref_level_upper_bit;
        prdata_q[ACAC_C1_LO_STAT]       <= lo_stat_q;
        prdata_q[ACAC_C1_HI_STAT]       <= hi_stat_q;
        prdata_q[ACAC_C1_BUSY]          <= state_q != ACAC_S_IDLE;
        prdata_q[ACAC_C1_POWERED]       <= powered_q;
      end else if (hit(PADDR, ACAC_OFF_RES_HI)) begin
        prdata_q[7:0] <= res_hi_q;
      end else if (hit(PADDR, ACAC_OFF_RES_LO)) begin
        prdata_q[7:0] <= res_lo_q;
      end else if (hit(PADDR, ACAC_OFF_THR_HI)) begin
        prdata_q[7:0] <= thr_hi_q;
      end else if (hit(PADDR, ACAC_OFF_THR_LO)) begin
        prdata_q[7:0] <= thr_lo_q;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  // go is accepted only while idle, so a busy converter is never restarted
  assign start_ok = state_q == ACAC_S_IDLE && !ctl0_q.conversion_go;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctl0_q <= ACAC_CTL0_RST;
    end else begin
      if (wr_ctl0) begin
        ctl0_q.vref_level_lower_bit <= PWDATA[6];
        ctl0_q.vref_pin_out         <= PWDATA[5];
        ctl0_q.repeat_select        <= PWDATA[4];
        ctl0_q.input_channel_sel    <= PWDATA[3:0];
        if (start_ok) begin
          ctl0_q.conversion_go <= PWDATA[7];
        end
      end
      if (first_done) begin
        ctl0_q.conversion_go <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      ctl1_q   <= '0;
      thr_hi_q <= ACAC_THR_RST;
      thr_lo_q <= ACAC_THR_RST;
    end else begin
      if (wr_ctl1) begin
        ctl1_q.input_stage_mode     <= PWDATA[ACAC_C1_MODE_LSB +: 3];
        ctl1_q.lower_alarm_en       <= PWDATA[ACAC_C1_LO_EN];
        ctl1_q.upper_alarm_en       <= PWDATA[ACAC_C1_HI_EN];
        ctl1_q.vref_level_upper_bit <= PWDATA[ACAC_C1_REFH];
      end else if (wr_thr_hi) begin
        thr_hi_q <= PWDATA[7:0];
      end else if (wr_thr_lo) begin
        thr_lo_q <= PWDATA[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // conversion sequencer
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ACAC_S_IDLE;
      cnt_q   <= '0;
    end else begin
      case (state_q)
        ACAC_S_IDLE: begin
          cnt_q <= '0;
          if (ctl0_q.conversion_go) begin
            state_q <= powered_q ? ACAC_S_CONV : ACAC_S_PWRUP;
          end
        end
        ACAC_S_PWRUP: begin
          if (cnt_q == PWRUP_LAST) begin
            cnt_q   <= '0;
            state_q <= ACAC_S_CONV;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ACAC_S_CONV: begin
          if (cnt_q == CONV_LAST) begin
            cnt_q   <= '0;
            state_q <= ctl0_q.repeat_select ? ACAC_S_REPEAT : ACAC_S_IDLE;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        ACAC_S_REPEAT: begin
          if (!ctl0_q.repeat_select) begin
            cnt_q   <= '0;
            state_q <= ACAC_S_IDLE;
          end else if (cnt_q == REP_LAST) begin
            cnt_q <= '0;
          end else begin
            cnt_q <= cnt_q + 1'b1;
          end
        end
        default: begin
          state_q <= ACAC_S_IDLE;
          cnt_q   <= '0;
        end
      endcase
    end
  end

  assign first_done = state_q == ACAC_S_CONV && cnt_q == CONV_LAST;
  // an abandoned repeat period yields no result
  assign done = first_done ||
                (state_q == ACAC_S_REPEAT && ctl0_q.repeat_select && cnt_q == REP_LAST);

  // idle timer; the wake-up path is taken only from the powered-down state
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      powered_q <= 1'b0;
      idle_q    <= '0;
    end else if (state_q != ACAC_S_IDLE) begin
      idle_q <= '0;
      if (state_q == ACAC_S_PWRUP && cnt_q == PWRUP_LAST) begin
        powered_q <= 1'b1;
      end
    end else if (powered_q) begin
      if (idle_q == IDLE_LAST) begin
        powered_q <= 1'b0;
        idle_q    <= '0;
      end else begin
        idle_q <= idle_q + 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // result placement and alarms
  // raw sample: [12:2] signed result, [1:0] extra precision for compensation
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      res_hi_q <= 8'h00;
      res_lo_q <= 8'h00;
    end else if (done) begin
      res_hi_q <= SAMPLE_DATA[12:5];
      res_lo_q <= {SAMPLE_DATA[4:0], 3'h0};
    end
  end

  assign is_neg   = SAMPLE_DATA[12];
  assign cmp_bits = SAMPLE_DATA[11:4];
  assign hi_hit   = !is_neg && (cmp_bits > thr_hi_q);
  assign lo_hit   = is_neg || (cmp_bits < thr_lo_q);

  // a new alarm wins over a same-cycle write-one clear
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      hi_stat_q <= 1'b0;
      lo_stat_q <= 1'b0;
    end else begin
      if (done && hi_hit) begin
        hi_stat_q <= 1'b1;
      end else if (wr_ctl1 && PWDATA[ACAC_C1_HI_STAT]) begin
        hi_stat_q <= 1'b0;
      end
      if (done && lo_hit) begin
        lo_stat_q <= 1'b1;
      end else if (wr_ctl1 && PWDATA[ACAC_C1_LO_STAT]) begin
        lo_stat_q <= 1'b0;
      end
    end
  end

  // request pulse only at a result, so an idle converter never interrupts;
  // pending state lives in the cpu interrupt controller
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= done && (
                 (!ctl1_q.upper_alarm_en && !ctl1_q.lower_alarm_en) ||
                 (ctl1_q.upper_alarm_en && hi_hit) ||
                 (ctl1_q.lower_alarm_en && lo_hit));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog-side controls, all from flops
  logic       active_q;
  logic [1:0] vref_q;
  logic       pin_q;
  logic [3:0] chan_q;
  logic [2:0] mode_q;

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      active_q <= 1'b0;
      vref_q   <= ACAC_REF_OFF;
      pin_q    <= 1'b0;
      chan_q   <= 4'h0;
      mode_q   <= 3'h0;
    end else begin
      active_q <= state_q == ACAC_S_CONV || state_q == ACAC_S_REPEAT;
      vref_q   <= {ctl1_q.vref_level_upper_bit, ctl0_q.vref_level_lower_bit};
      // the reference reaches the pin only while the internal one runs
      pin_q    <= ctl0_q.vref_pin_out &&
                  ({ctl1_q.vref_level_upper_bit, ctl0_q.vref_level_lower_bit} != ACAC_REF_OFF);
      chan_q   <= ctl0_q.input_channel_sel;
      mode_q   <= ctl1_q.input_stage_mode;
    end
  end

  assign PRDATA            = prdata_q;
  assign PREADY            = pready_q;
  assign PSLVERR           = pslverr_q;
  assign ANALOG_POWERED    = powered_q;
  assign CONV_ACTIVE       = active_q;
  assign INPUT_CHANNEL_SEL = chan_q;
  assign INPUT_STAGE_MODE  = mode_q;
  assign VREF_LEVEL        = vref_q;
  assign VREF_PIN_OUT      = pin_q;
  assign ADC_IRQ           = irq_q;

endmodule
`default_nettype wire

// ==== tb/acac_top_chk.sv ====
// port-level assertion checker of the converter control block
`timescale 1ns/100ps
`default_nettype none
module acac_chk
  import acac_pkg::*;
#(
  parameter int CONV_CYCLES = ACAC_CONV_CYCLES
) (
  input wire logic                  CLOCK,
  input wire logic                  RST_N,
  input wire logic                  PSEL,
  input wire logic                  PENABLE,
  input wire logic                  PWRITE,
  input wire logic [7:0]            PADDR,
  input wire logic [31:0]           PWDATA,
  input wire logic [31:0]           PRDATA,
  input wire logic                  PREADY,
  input wire logic                  PSLVERR,
  input wire logic [ACAC_RAW_W-1:0] SAMPLE_DATA,
  input wire logic                  ANALOG_POWERED,
  input wire logic                  CONV_ACTIVE,
  input wire logic [3:0]            INPUT_CHANNEL_SEL,
  input wire logic [2:0]            INPUT_STAGE_MODE,
  input wire logic [1:0]            VREF_LEVEL,
  input wire logic                  VREF_PIN_OUT,
  input wire logic                  ADC_IRQ
);
  logic [31:0] idle_q;
  logic [31:0] act_q;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // idle count lags the state by one cycle, hence the window below
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) idle_q <= 32'h0;
    else if (CONV_ACTIVE || !ANALOG_POWERED) idle_q <= 32'h0;
    else idle_q <= idle_q + 32'h1;
  end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) act_q <= 32'h0;
    else if (!CONV_ACTIVE) act_q <= 32'h0;
    else act_q <= act_q + 32'h1;
  end
  ////////////////////////////////////////
  a_setup_ready: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  a_ready_single: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_bad_addr_quiet: assert property (PSLVERR |-> PREADY && PRDATA == 32'h0)
    else $error("error response malformed");
  a_irq_pulse: assert property (ADC_IRQ |=> !ADC_IRQ)
    else $error("interrupt not a single pulse");
  a_pin_needs_ref: assert property (VREF_PIN_OUT |-> VREF_LEVEL != 2'h0)
    else $error("reference pin driven with reference off");
  a_irq_when_active: assert property (ADC_IRQ |-> $past(CONV_ACTIVE))
    else $error("interrupt while converter idle");
  a_idle_power_down: assert property ($fell(ANALOG_POWERED) |-> idle_q >= 32'h9D && idle_q <= 32'hA2)
    else $error("power down at wrong idle count");
  a_conv_min_len: assert property ($fell(CONV_ACTIVE) |-> act_q >= CONV_CYCLES - 1)
    else $error("conversion ended early");
endmodule
bind acac_top acac_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .SAMPLE_DATA(SAMPLE_DATA), .ANALOG_POWERED(ANALOG_POWERED), .CONV_ACTIVE(CONV_ACTIVE),
  .INPUT_CHANNEL_SEL(INPUT_CHANNEL_SEL), .INPUT_STAGE_MODE(INPUT_STAGE_MODE), .VREF_LEVEL(VREF_LEVEL),
  .VREF_PIN_OUT(VREF_PIN_OUT), .ADC_IRQ(ADC_IRQ));
`default_nettype wire

// ==== tb/tb_adc_conversion_alarm_control.sv ====
// self-checking bench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_adc_conversion_alarm_control;
  import acac_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} acac_row_t;
  typedef struct {logic [12:0] raw; logic [1:0] en; logic irq; logic [1:0] st;} acac_alm_t;
  logic        clock = 1'h0;
  logic        rst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [12:0] sample = 13'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, powered, active, pin, irq, er;
  logic [3:0]  chan;
  logic [2:0]  mode;
  logic [1:0]  vref;
  logic [31:0] rd;
  int          n_fail = 0, samples_checked = 0, cyc = 0, n;
  // short conversion keeps the run brief; the first-result timing below derives from it
  acac_top #(.CONV_CYCLES(20)) i_dut (.CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .SAMPLE_DATA(sample), .ANALOG_POWERED(powered), .CONV_ACTIVE(active), .INPUT_CHANNEL_SEL(chan),
    .INPUT_STAGE_MODE(mode), .VREF_LEVEL(vref), .VREF_PIN_OUT(pin), .ADC_IRQ(irq));
  always #25 clock = ~clock;
  ////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // request held until the edge that sees pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(nm, rd & m, x);
  endtask
  // n is the edge count from the last access edge, zero when none came
  task automatic wait_irq(input int lim, output int k);
    k = 0;
    for (int i = 1; i <= lim && k == 0; i++) begin
      @(posedge clock);
      #1;
      if (irq === 1'h1) k = i;
    end
  endtask
  ////////////////////////////////////////
  acac_row_t rows [12] = '{
    '{1'h0, ACAC_OFF_CTL0, 32'h0, 32'h0, 1'h0}, '{1'h0, ACAC_OFF_CTL1, 32'h0, 32'h0, 1'h0},
    '{1'h0, ACAC_OFF_RES_HI, 32'h0, 32'h0, 1'h0}, '{1'h0, ACAC_OFF_RES_LO, 32'h0, 32'h0, 1'h0},
    '{1'h1, ACAC_OFF_THR_HI, 32'hA5, 32'h0, 1'h0}, '{1'h0, ACAC_OFF_THR_HI, 32'h0, 32'hA5, 1'h0},
    '{1'h1, ACAC_OFF_CTL1, 32'hFF, 32'h0, 1'h0}, '{1'h0, ACAC_OFF_CTL1, 32'h0, 32'h3F, 1'h0},
    '{1'h1, 8'h18, 32'h1, 32'h0, 1'h1}, '{1'h0, 8'h18, 32'h0, 32'h0, 1'h1},
    '{1'h1, ACAC_OFF_CTL0, 32'h6F, 32'h0, 1'h0}, '{1'h0, ACAC_OFF_CTL0, 32'h0, 32'h6F, 1'h0}};
  acac_alm_t alm [5] = '{'{13'h0800, 2'h3, 1'h1, 2'h2}, '{13'h1000, 2'h2, 1'h0, 2'h1},
    '{13'h0050, 2'h1, 1'h1, 2'h1}, '{13'h0200, 2'h3, 1'h0, 2'h0}, '{13'h1FF0, 2'h2, 1'h0, 2'h1}};
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("rdata", rd, rows[i].x);
      chk("slverr", er, rows[i].e);
    end
    repeat (2) @(posedge clock);
    #1;
    chk("chan", chan, 4'hF);
    chk("mode", mode, 3'h7);
    chk("vref", vref, 2'h3);
    chk("pin", pin, 1'h1);
    apb(1'h1, ACAC_OFF_CTL1, 32'h0);
    apb(1'h1, ACAC_OFF_CTL0, 32'h20);
    repeat (2) @(posedge clock);
    #1;
    chk("pin off", pin, 1'h0);
    $display("test registers done");
    apb(1'h1, ACAC_OFF_THR_HI, 32'h40);
    apb(1'h1, ACAC_OFF_THR_LO, 32'h10);
    sample <= 13'h0AB5;
    apb(1'h1, ACAC_OFF_CTL0, 32'h83);
    apb(1'h1, ACAC_OFF_CTL0, 32'h83);
    rdc("go busy", ACAC_OFF_CTL0, 32'h80, 32'h80);
    wait_irq(100, n);
    chk("first result", n, 55);
    rdc("go done", ACAC_OFF_CTL0, 32'h80, 32'h0);
    rdc("res hi", ACAC_OFF_RES_HI, 32'hFFFFFFFF, 32'h55);
    rdc("res lo", ACAC_OFF_RES_LO, 32'hFFFFFFFF, 32'hA8);
    rdc("status", ACAC_OFF_CTL1, 32'hC0, 32'h80);
    chk("powered", powered, 1'h1);
    $display("test single shot done");
    foreach (alm[i]) begin
      sample <= alm[i].raw;
      apb(1'h1, ACAC_OFF_CTL1, {24'h0, 3'h6, alm[i].en, 3'h0});
      apb(1'h1, ACAC_OFF_CTL0, 32'h83);
      wait_irq(60, n);
      chk("alarm irq", n, alm[i].irq ? 21 : 0);
      rdc("alarm stat", ACAC_OFF_CTL1, 32'hC0, {24'h0, alm[i].st, 6'h0});
    end
    apb(1'h1, ACAC_OFF_CTL1, 32'h0);
    rdc("w0 keeps", ACAC_OFF_CTL1, 32'hC0, 32'h40);
    apb(1'h1, ACAC_OFF_CTL1, 32'h40);
    rdc("w1 clears", ACAC_OFF_CTL1, 32'hC0, 32'h0);
    $display("test alarms done");
    sample <= 13'h0100;
    apb(1'h1, ACAC_OFF_CTL0, 32'h90);
    wait_irq(100, n);
    chk("repeat_select first", n, 21);
    rdc("repeat_select go", ACAC_OFF_CTL0, 32'h80, 32'h0);
    sample <= 13'h0AB5;
    wait_irq(300, n);
    chk("repeat_select period", n, 253);
    rdc("repeat_select res", ACAC_OFF_RES_HI, 32'hFFFFFFFF, 32'h55);
    apb(1'h1, ACAC_OFF_CTL0, 32'h0);
    wait_irq(300, n);
    chk("repeat_select stop", n, 0);
    chk("inactive", active, 1'h0);
    repeat (170) @(posedge clock);
    #1;
    chk("powered down", powered, 1'h0);
    $display("test continuous done");
    apb(1'h1, ACAC_OFF_CTL0, 32'h5A);
    rst_n <= 1'h0;
    repeat (2) @(posedge clock);
    rst_n <= 1'h1;
    rdc("ctl0 reset", ACAC_OFF_CTL0, 32'hFFFFFFFF, 32'h0);
    rdc("thr reset", ACAC_OFF_THR_HI, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    end_sim();
  end
endmodule
`default_nettype wire
